// [acc_pkg.sv]
// package of constants and types for the conversion control block
package acc_pkg;

    // ****************************************
    // register indices; byte address = 4 * index
    // ****************************************
    localparam logic [7:0]  ACC_IDX_RES_LO   = 8'h24;
    localparam logic [7:0]  ACC_IDX_RES_HI   = 8'h25;
    localparam logic [7:0]  ACC_IDX_CTRL     = 8'h26;
    localparam logic [7:0]  ACC_IDX_CLKSEL   = 8'h27;
    localparam logic [7:0]  ACC_IDX_IRQ_STAT = 8'h28;
    localparam logic [7:0]  ACC_IDX_IRQ_CLR  = 8'h29;
    localparam logic [7:0]  ACC_IDX_IRQ_EN   = 8'h2A;
    localparam logic [7:0]  ACC_IDX_GIE      = 8'h2B;
    localparam int          ACC_ADDR_W       = 12;

    // ****************************************
    // field positions and reset values
    // ****************************************
    localparam int          ACC_CTRL_START_BIT = 7;
    localparam int          ACC_CTRL_EOC_BIT   = 6;
    localparam int          ACC_CLKSEL_TEST_BIT = 7;
    localparam int          ACC_IRQ_DONE_BIT   = 0;
    localparam int          ACC_RES_LO_LSB_BIT = 7;
    localparam logic [7:0]  ACC_CTRL_RST       = 8'h00;
    localparam logic [7:0]  ACC_CLKSEL_RST     = 8'h00;
    localparam logic [8:0]  ACC_RESULT_RST     = 9'h000;

    // ****************************************
    // conversion clock selection and timing in conversion-clock periods
    // ****************************************
    localparam logic [1:0]  ACC_DIV2_SEL     = 2'h0;
    localparam logic [1:0]  ACC_DIV8_SEL     = 2'h1;
    localparam logic [1:0]  ACC_DIV32_SEL    = 2'h2;
    localparam logic [4:0]  ACC_DIV2_TERM    = 5'h01;
    localparam logic [4:0]  ACC_DIV8_TERM    = 5'h07;
    localparam logic [4:0]  ACC_DIV32_TERM   = 5'h1F;
    localparam logic [6:0]  ACC_SAMPLE_TAPS  = 7'h20;   // 32 periods
    localparam logic [6:0]  ACC_TOTAL_TAPS   = 7'h4C;   // 76 periods
    localparam logic [6:0]  ACC_SAR_END_TAP  = 7'h44;   // 32 + 9 bits * 4
    localparam int          ACC_RES_W        = 9;

    // ****************************************
    // carrier types
    // ****************************************
    typedef struct packed {
        logic       start;
        logic       eoc;
        logic [2:0] port_cfg;
        logic [2:0] channel_sel;
    } acc_ctrl_t;

    typedef struct packed {
        logic       psel;
        logic       penable;
        logic       pwrite;
        logic [ACC_ADDR_W-1:0] paddr;
        logic [31:0] pwdata;
    } acc_apb_req_t;

    typedef struct packed {
        logic       prdata_valid_unused;
        logic       pready;
        logic       pslverr;
        logic [31:0] prdata;
    } acc_apb_rsp_t;

    typedef struct packed {
        logic       power_en;
        logic       sample_en;
        logic [2:0] channel;
        logic [ACC_RES_W-1:0] dac_code;
        logic [7:0] port_b_analog;
    } acc_ana_t;

    typedef enum logic [0:0] {
        ACC_IDLE,
        ACC_CONV
    } acc_state_t;

endpackage

// [acc_tap_div.sv]
// conversion clock tick generator dividing the system clock
`timescale 1ns/10ps
module acc_tap_div (
    // clock and reset
    input  wire logic       sys_clk,
    input  wire logic       nrst,
    // control
    input  wire logic [1:0] div_sel,
    input  wire logic       run,
    // tick out
    output logic            tap
);
    import acc_pkg::*;

    logic [4:0] cnt_q;
    logic [4:0] term;
    logic       tap_q;

    // ****************************************
    // divider terminal count
    // ****************************************
    // RULE8 only 2, 8, 32
    always_comb begin
        case (div_sel)
            ACC_DIV2_SEL:  term = ACC_DIV2_TERM;
            ACC_DIV8_SEL:  term = ACC_DIV8_TERM;
            ACC_DIV32_SEL: term = ACC_DIV32_TERM;
            default:       term = ACC_DIV32_TERM;   // undefined code runs slowest
        endcase
    end

    // counter restarts whenever no conversion runs
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            cnt_q <= 5'h00;
            tap_q <= 1'b0;
        end else if (!run) begin
            cnt_q <= 5'h00;
            tap_q <= 1'b0;
        end else if (cnt_q >= term) begin
            cnt_q <= 5'h00;
            tap_q <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 5'h01;
            tap_q <= 1'b0;
        end
    end

    assign tap = tap_q;
endmodule

// [acc_top.sv]
// conversion control unit with apb registers, sequencer and interrupt
//
// Functional notes
// RULE1 - software may poll the end flag until it reads zero, then read result
// RULE2 - a finished conversion raises a maskable interrupt
// RULE3 - clock-select value one picks system clock divided by eight
// RULE4 - control value 0x20 makes four port-b lines analog, channel zero selected
// RULE5 - software pulses start low-high-low soon after changing port configuration
// RULE6 - software reads the high result byte, then the low byte
// RULE7 - interrupt mode: clear request flag, then enable unit and global interrupt
// RULE8 - conversion clock is system clock divided by 2, 8 or 32 only
// RULE9 - sampling lasts 32 conversion periods, whole conversion 76 periods
// RULE10 - service routine may restart conversion right after reading result
// RULE11 - start rising resets converter and sets end flag; falling begins conversion
// RULE12 - completion clears end flag, sets request flag; irq only when enabled
// RULE13 - result upper eight bits in high byte, lsb in low byte bit 7
// RULE14 - channel field selects input in binary; port field zero powers off
// RULE15 - result bytes stay stable from completion until next start
//
// Design decisions made here: the register addresses and the APB interface to the registers.
`timescale 1ns/10ps
module acc_top (
    // clock and reset
    input  wire logic                 sys_clk,
    input  wire logic                 nrst,
    // apb slave
    input  wire acc_pkg::acc_apb_req_t apb_req,
    output acc_pkg::acc_apb_rsp_t      apb_rsp,
    // analog front end
    input  wire logic                 cmp_above,
    output acc_pkg::acc_ana_t          ana,
    // interrupt
    output logic                      irq
);
    import acc_pkg::*;

    acc_ctrl_t              ctrl_q;
    logic [7:0]             clksel_q;
    logic [ACC_RES_W-1:0]   result_q;
    logic                   irq_stat_q;
    logic                   irq_en_q;
    logic                   gie_q;
    logic                   start_prev_q;
    acc_state_t             state_q;
    logic [6:0]             tap_cnt_q;
    logic [ACC_RES_W-1:0]   sar_q;
    acc_apb_rsp_t           rsp_q;
    acc_ana_t               ana_q;
    logic                   irq_q;
    logic                   tap;
    logic                   wr_en;
    logic                   start_rise;
    logic                   start_fall;
    logic                   powered;
    logic                   done;
    logic [3:0]             bit_k;
    logic [31:0]            rd_data;
    logic                   rd_hit;

    // ****************************************
    // address decode
    // ****************************************
    function automatic logic reg_hit(input logic [ACC_ADDR_W-1:0] addr, input logic [7:0] idx);
        reg_hit = (addr == {2'b00, idx, 2'b00});
    endfunction

    // port-b analog mask: the lowest n lines for configuration n, all eight for seven
    function automatic logic [7:0] port_mask(input logic [2:0] cfg);
        logic [7:0] m;
        m = 8'h00;
        case (cfg)
            3'h0:    m = 8'h00;
            3'h1:    m = 8'h01;
            3'h2:    m = 8'h03;
            3'h3:    m = 8'h07;
            3'h4:    m = 8'h0F;
            3'h5:    m = 8'h1F;
            3'h6:    m = 8'h3F;
            default: m = 8'hFF;
        endcase
        port_mask = m;
    endfunction

    // write takes effect in the access phase, which always ends in one cycle
    assign wr_en = apb_req.psel & apb_req.penable & apb_req.pwrite & rsp_q.pready;

    // ****************************************
    // read mux
    // ****************************************
    always_comb begin
        rd_data = 32'h0000_0000;
        rd_hit  = 1'b1;
        // RULE13 result byte layout
        if (reg_hit(apb_req.paddr, ACC_IDX_RES_LO)) begin
            rd_data[ACC_RES_LO_LSB_BIT] = result_q[0];
        end else if (reg_hit(apb_req.paddr, ACC_IDX_RES_HI)) begin
            rd_data[7:0] = result_q[8:1];
        end else if (reg_hit(apb_req.paddr, ACC_IDX_CTRL)) begin
            rd_data[7:0] = ctrl_q;
        end else if (reg_hit(apb_req.paddr, ACC_IDX_CLKSEL)) begin
            rd_data[7:0] = {clksel_q[ACC_CLKSEL_TEST_BIT], 5'h00, clksel_q[1:0]};
        end else if (reg_hit(apb_req.paddr, ACC_IDX_IRQ_STAT)) begin
            rd_data[ACC_IRQ_DONE_BIT] = irq_stat_q;
        end else if (reg_hit(apb_req.paddr, ACC_IDX_IRQ_CLR)) begin
            rd_data = 32'h0000_0000;   // write-only, reads zero
        end else if (reg_hit(apb_req.paddr, ACC_IDX_IRQ_EN)) begin
            rd_data[ACC_IRQ_DONE_BIT] = irq_en_q;
        end else if (reg_hit(apb_req.paddr, ACC_IDX_GIE)) begin
            rd_data[0] = gie_q;
        end else begin
            rd_hit = 1'b0;
        end
    end

    // ****************************************
    // apb response, registered in the setup cycle
    // ****************************************
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rsp_q <= '0;
        end else begin
            rsp_q.prdata_valid_unused <= 1'b0;
            rsp_q.pready  <= apb_req.psel & ~apb_req.penable;
            rsp_q.pslverr <= apb_req.psel & ~apb_req.penable & ~rd_hit;
            rsp_q.prdata  <= (apb_req.psel & ~apb_req.penable & ~apb_req.pwrite) ? rd_data : 32'h0000_0000;
        end
    end

    // ****************************************
    // software-written configuration
    // ****************************************
    // RULE3 RULE4 RULE14 config writes
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_q.start       <= ACC_CTRL_RST[ACC_CTRL_START_BIT];
            ctrl_q.eoc         <= ACC_CTRL_RST[ACC_CTRL_EOC_BIT];
            ctrl_q.port_cfg    <= ACC_CTRL_RST[5:3];
            ctrl_q.channel_sel <= ACC_CTRL_RST[2:0];
            clksel_q           <= ACC_CLKSEL_RST;
            irq_en_q           <= 1'b0;
            gie_q              <= 1'b0;
        end else begin
            if (wr_en) begin
                if (reg_hit(apb_req.paddr, ACC_IDX_CTRL)) begin
                    ctrl_q.start       <= apb_req.pwdata[ACC_CTRL_START_BIT];
                    ctrl_q.port_cfg    <= apb_req.pwdata[5:3];
                    ctrl_q.channel_sel <= apb_req.pwdata[2:0];
                end
                if (reg_hit(apb_req.paddr, ACC_IDX_CLKSEL)) begin
                    clksel_q <= {apb_req.pwdata[ACC_CLKSEL_TEST_BIT], 5'h00, apb_req.pwdata[1:0]};
                end
                if (reg_hit(apb_req.paddr, ACC_IDX_IRQ_EN)) begin
                    irq_en_q <= apb_req.pwdata[ACC_IRQ_DONE_BIT];
                end
                if (reg_hit(apb_req.paddr, ACC_IDX_GIE)) begin
                    gie_q <= apb_req.pwdata[0];
                end
            end
            // RULE11 RULE12 end flag, one driver with the rest of the control byte
            if (start_rise) begin
                ctrl_q.eoc <= 1'b1;
            end else if (done && powered && !start_fall) begin
                ctrl_q.eoc <= 1'b0;
            end
        end
    end

    // ****************************************
    // start edge detection and power
    // ****************************************
    assign start_rise = ctrl_q.start & ~start_prev_q;
    assign start_fall = ~ctrl_q.start & start_prev_q;
    assign powered    = (ctrl_q.port_cfg != 3'h0);
    assign done       = (state_q == ACC_CONV) & tap & (tap_cnt_q == ACC_TOTAL_TAPS - 7'h01);
    assign bit_k      = 4'((tap_cnt_q - ACC_SAMPLE_TAPS) >> 2);

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            start_prev_q <= 1'b0;
        end else begin
            start_prev_q <= ctrl_q.start;
        end
    end

    // conversion clock ticks
    acc_tap_div u_tap_div (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .div_sel (clksel_q[1:0]),
        .run     (state_q == ACC_CONV),
        .tap     (tap)
    );

    // ****************************************
    // conversion sequencer
    // ****************************************
    // RULE11 start edges
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state_q   <= ACC_IDLE;
            tap_cnt_q <= 7'h00;
            sar_q     <= ACC_RESULT_RST;
        end else if (start_rise || !powered) begin
            state_q   <= ACC_IDLE;             // reset converter, off when unpowered
            tap_cnt_q <= 7'h00;
            sar_q     <= ACC_RESULT_RST;
        end else if (start_fall) begin
            state_q   <= ACC_CONV;
            tap_cnt_q <= 7'h00;
            sar_q     <= ACC_RESULT_RST;
        end else begin
            case (state_q)
                ACC_IDLE: begin
                    tap_cnt_q <= 7'h00;
                end
                ACC_CONV: begin
                    if (tap) begin
                        // RULE9 32 sample, 76 total
                        if (done) begin
                            state_q <= ACC_IDLE;
                        end
                        tap_cnt_q <= tap_cnt_q + 7'h01;
                        if (tap_cnt_q >= ACC_SAMPLE_TAPS && tap_cnt_q < ACC_SAR_END_TAP) begin
                            if (tap_cnt_q[1:0] == 2'h0) begin
                                sar_q[4'd8 - bit_k] <= 1'b1;   // trial bit
                            end else if (tap_cnt_q[1:0] == 2'h3 && !cmp_above) begin
                                sar_q[4'd8 - bit_k] <= 1'b0;   // input below trial
                            end
                        end
                    end
                end
                default: begin
                    state_q <= ACC_IDLE;
                end
            endcase
        end
    end

    // ****************************************
    // conversion result
    // ****************************************
    // RULE12 RULE15 result latch, held until the next completion
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            result_q <= ACC_RESULT_RST;
        end else if (done && powered && !start_rise && !start_fall) begin
            result_q <= sar_q;
        end
    end

    // ****************************************
    // interrupt status, clear and output
    // ****************************************
    // RULE2 RULE12 sticky flag, set wins
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            irq_stat_q <= 1'b0;
            irq_q      <= 1'b0;
        end else begin
            if (done && powered && !start_rise && !start_fall) begin
                irq_stat_q <= 1'b1;
            end else if (wr_en && reg_hit(apb_req.paddr, ACC_IDX_IRQ_CLR) && apb_req.pwdata[ACC_IRQ_DONE_BIT]) begin
                irq_stat_q <= 1'b0;
            end
            irq_q <= irq_stat_q & irq_en_q & gie_q;
        end
    end

    // ****************************************
    // analog front-end controls
    // ****************************************
    // RULE14 channel and power
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            ana_q <= '0;
        end else begin
            ana_q.power_en      <= powered;
            ana_q.sample_en     <= (state_q == ACC_CONV) && (tap_cnt_q < ACC_SAMPLE_TAPS);
            ana_q.channel       <= ctrl_q.channel_sel;
            ana_q.dac_code      <= sar_q;
            ana_q.port_b_analog <= port_mask(ctrl_q.port_cfg);
        end
    end

    assign apb_rsp = rsp_q;
    assign ana     = ana_q;
    assign irq     = irq_q;
endmodule

// [acc_props.sv]
// port-level checker for the conversion control unit
`timescale 1ns/10ps
module acc_props (
    // clock and reset
    input wire logic                  sys_clk,
    input wire logic                  nrst,
    // apb
    input wire acc_pkg::acc_apb_req_t apb_req,
    input wire acc_pkg::acc_apb_rsp_t apb_rsp,
    // analog front end and interrupt
    input wire logic                  cmp_above,
    input wire acc_pkg::acc_ana_t     ana,
    input wire logic                  irq
);
    import acc_pkg::*;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    // ****************************************
    // mirror of the written settings
    // ****************************************
    logic        setup;
    logic        wr;
    logic        mapped;
    logic [1:0]  div_q;
    logic [5:0]  cfg_q;
    logic        en_q;
    logic        gie_q;
    logic [11:0] smp_q;
    int          taps;
    logic [7:0]  mask;

    // request phase decode, writes land at the ready edge
    assign setup  = apb_req.psel && !apb_req.penable;
    assign wr     = apb_req.psel && apb_req.penable && apb_req.pwrite && apb_rsp.pready;
    assign mapped = apb_req.paddr[11:2] inside {[10'h024:10'h02B]} && apb_req.paddr[1:0] == 2'h0;
    assign taps   = (div_q == ACC_DIV2_SEL) ? 2 : (div_q == ACC_DIV8_SEL) ? 8 : 32;
    assign mask   = (cfg_q[5:3] == 3'h7) ? 8'hFF : (8'h01 << cfg_q[5:3]) - 8'h01;

    // register copies taken from completed writes
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            div_q <= 2'h0;
            cfg_q <= 6'h00;
            en_q  <= 1'b0;
            gie_q <= 1'b0;
        end else if (wr) begin
            if (apb_req.paddr[11:2] == {2'h0, ACC_IDX_CLKSEL}) div_q <= apb_req.pwdata[1:0];
            if (apb_req.paddr[11:2] == {2'h0, ACC_IDX_CTRL}) cfg_q <= apb_req.pwdata[5:0];
            if (apb_req.paddr[11:2] == {2'h0, ACC_IDX_IRQ_EN}) en_q <= apb_req.pwdata[0];
            if (apb_req.paddr[11:2] == {2'h0, ACC_IDX_GIE}) gie_q <= apb_req.pwdata[0];
        end
    end

    // length of the current sampling window in system cycles
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            smp_q <= 12'h000;
        end else begin
            smp_q <= ana.sample_en ? smp_q + 12'h001 : 12'h000;
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    AST_READY_AFTER_SETUP: assert property (setup |=> apb_rsp.pready)
        else $error("no ready in the access cycle");
    AST_READY_ONE_CYCLE: assert property (apb_rsp.pready |=> !apb_rsp.pready)
        else $error("ready held longer than one cycle");
    AST_ERR_UNMAPPED: assert property (setup |=> apb_rsp.pslverr == !$past(mapped))
        else $error("error response does not match the address");
    AST_RDATA_CLEAN: assert property (apb_rsp.prdata[31:8] == 24'h0 && (apb_rsp.pready || apb_rsp.prdata == 32'h0))
        else $error("read data outside a read answer");
    AST_IRQ_ONLY_ENABLED: assert property ($rose(irq) |-> $past(en_q && gie_q))
        else $error("interrupt raised while masked");
    AST_IRQ_HOLDS: assert property (irq && !wr && !$past(wr) |=> irq)
        else $error("interrupt dropped without a write");
    AST_SAMPLE_LENGTH: assert property ($fell(ana.sample_en) |-> smp_q >= 32 * taps - 1 && smp_q <= 32 * taps + 2)
        else $error("sampling window has the wrong length");
    AST_POWER_FOLLOWS_CFG: assert property ($stable(cfg_q)[*3] |-> ana.power_en == (cfg_q[5:3] != 3'h0) && ana.port_b_analog == mask)
        else $error("power or analog lines differ from the port field");
    AST_CHANNEL_FOLLOWS: assert property ($stable(cfg_q)[*3] |-> ana.channel == cfg_q[2:0])
        else $error("channel output differs from the channel field");

    // main scenarios reached
    CV_IRQ: cover property ($rose(irq));
    CV_SAMPLE_DONE: cover property ($fell(ana.sample_en));
    CV_SLVERR: cover property (apb_rsp.pslverr);
endmodule

bind acc_top acc_props u_props (
    .sys_clk   (sys_clk),
    .nrst      (nrst),
    .apb_req   (apb_req),
    .apb_rsp   (apb_rsp),
    .cmp_above (cmp_above),
    .ana       (ana),
    .irq       (irq)
);

// [tb.sv]
// self-checking testbench for the conversion control unit
`timescale 1ns/10ps
module tb;
    import acc_pkg::*;
    typedef struct packed {
        logic [11:0] addr;
        logic        wr;
        logic [7:0]  wdata;
        logic [7:0]  rdata;
        logic        err;
    } acc_row_t;
    logic         sys_clk = 1'b0;
    logic         nrst;
    acc_apb_req_t apb_req;
    acc_apb_rsp_t apb_rsp;
    logic         cmp_above;
    acc_ana_t     ana;
    logic         irq;
    logic [8:0]   vin;
    logic [31:0]  rd;
    logic         er;
    int           num_errors = 0;
    int           comparisons = 0;
    int           cyc = 0;
    acc_row_t     rows [0:11];

    acc_top dut (
        .sys_clk   (sys_clk),
        .nrst      (nrst),
        .apb_req   (apb_req),
        .apb_rsp   (apb_rsp),
        .cmp_above (cmp_above),
        .ana       (ana),
        .irq       (irq)
    );

    // clock at 10 MHz
    always #50 sys_clk = ~sys_clk;

    // cycle count and a comparator whose input sits half a step above vin
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        cmp_above <= (ana.dac_code <= vin);
    end

    // ****************************************
    // tasks
    // ****************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %0t: seen %h expected %h", $time, got, exp);
        end
    endtask

    // one apb transfer, held until ready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        apb_req.psel <= 1'b1;
        apb_req.pwrite <= w;
        apb_req.paddr <= a;
        apb_req.pwdata <= {24'h0, d};
        @(posedge sys_clk);
        apb_req.penable <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (apb_rsp.pready !== 1'b1 && n < 20);
        if (n >= 20) num_errors++;
        rd = apb_rsp.prdata;
        er = apb_rsp.pslverr;
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
    endtask

    // one conversion: start pulse, poll the end flag, read result
    task automatic conv(input logic [1:0] sel, input logic [7:0] ctl, input logic en, input logic [8:0] v);
        int t0;
        int d;
        d = (sel == ACC_DIV2_SEL) ? 2 : (sel == ACC_DIV8_SEL) ? 8 : 32;
        vin = v;
        apb(1'b1, 12'h09C, {6'h00, sel});
        apb(1'b1, 12'h0A8, {7'h00, en});
        apb(1'b1, 12'h0A4, 8'h01);
        // start pulse raised by the same write that sets the port field
        apb(1'b1, 12'h098, ctl | 8'h80);
        apb(1'b0, 12'h098, 8'h00);
        chk(rd, {24'h0, ctl | 8'hC0});
        apb(1'b1, 12'h098, ctl);
        t0 = cyc;
        rd = 32'h40;
        while (rd[6] === 1'b1 && cyc - t0 < 4000) apb(1'b0, 12'h098, 8'h00);
        chk(cyc - t0 >= 76 * d && cyc - t0 <= 76 * d + 12, 1'b1);
        chk(rd, {24'h0, ctl});
        chk(irq, en);
        apb(1'b0, 12'h0A0, 8'h00);
        chk(rd, 32'h1);
        apb(1'b0, 12'h094, 8'h00);
        chk(rd, {24'h0, v[8:1]});
        apb(1'b0, 12'h090, 8'h00);
        chk(rd, {24'h0, v[0], 7'h00});
        apb(1'b1, 12'h0A4, 8'h01);
        repeat (2) @(posedge sys_clk);
        chk(irq, 1'b0);
        $display("conversion test done, divider %0d", d);
    endtask

    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // watchdog well beyond the expected run length
    initial begin
        repeat (20000) @(posedge sys_clk);
        num_errors++;
        stop_test;
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        nrst = 1'b0;
        apb_req = '0;
        vin = 9'h000;
        rows = '{'{12'h09C, 1'b1, 8'h01, 8'h00, 1'b0}, '{12'h09C, 1'b0, 8'h00, 8'h01, 1'b0},
                 '{12'h09C, 1'b1, 8'hFF, 8'h00, 1'b0}, '{12'h09C, 1'b0, 8'h00, 8'h83, 1'b0},
                 '{12'h0A8, 1'b1, 8'h01, 8'h00, 1'b0}, '{12'h0A8, 1'b0, 8'h00, 8'h01, 1'b0},
                 '{12'h0AC, 1'b1, 8'h01, 8'h00, 1'b0}, '{12'h0AC, 1'b0, 8'h00, 8'h01, 1'b0},
                 '{12'h094, 1'b1, 8'h5A, 8'h00, 1'b0}, '{12'h094, 1'b0, 8'h00, 8'h00, 1'b0},
                 '{12'h0B0, 1'b1, 8'h11, 8'h00, 1'b1}, '{12'h0B0, 1'b0, 8'h00, 8'h00, 1'b1}};
        repeat (12) @(posedge sys_clk);
        nrst <= 1'b1;
        foreach (rows[i]) begin
            apb(rows[i].wr, rows[i].addr, rows[i].wdata);
            if (!rows[i].wr) chk(rd, {24'h0, rows[i].rdata});
            chk(er, rows[i].err);
        end
        $display("register table test done");
        // second reset in mid-run clears the settings
        @(posedge sys_clk);
        nrst <= 1'b0;
        repeat (2) @(posedge sys_clk);
        nrst <= 1'b1;
        apb(1'b0, 12'h09C, 8'h00);
        chk(rd, 32'h0);
        apb(1'b0, 12'h0A8, 8'h00);
        chk(rd, 32'h0);
        $display("reset test done");
        apb(1'b1, 12'h0AC, 8'h01);
        conv(ACC_DIV8_SEL, 8'h20, 1'b1, 9'h155);
        chk(ana.port_b_analog, 32'h0F);
        chk(ana.channel, 32'h0);
        apb(1'b1, 12'h098, 8'hA0);
        apb(1'b1, 12'h098, 8'h20);
        apb(1'b0, 12'h098, 8'h00);
        chk(rd, 32'h60);
        repeat (700) @(posedge sys_clk);
        apb(1'b0, 12'h094, 8'h00);
        chk(rd, 32'hAA);
        $display("restart test done");
        conv(ACC_DIV2_SEL, 8'h3D, 1'b0, 9'h000);
        conv(ACC_DIV32_SEL, 8'h0F, 1'b1, 9'h1FF);
        // port field zero: start pulse gives no completion, result kept
        apb(1'b1, 12'h09C, 8'h00);
        apb(1'b1, 12'h098, 8'h80);
        apb(1'b1, 12'h098, 8'h00);
        repeat (200) @(posedge sys_clk);
        apb(1'b0, 12'h0A0, 8'h00);
        chk(rd, 32'h0);
        apb(1'b0, 12'h094, 8'h00);
        chk(rd, 32'hFF);
        $display("power-off test done");
        stop_test;
    end
endmodule
